// File: rtl/lac_fsm.sv
// Layer 1 activation/deactivation machine for one basic-rate line interface.
// Assumes a one-cycle frame strobe per line frame and receive classification
// (signal code, bit/frame sync) from the receive path, all synchronous.
//
// Operation
// R1 - Reset holds state 0, sends nothing, ignores line until load bit written zero.
// R2 - NT pending to active on INFO3 needs one-shot allow or auto enable.
// R3 - Software releases the machine only after line interface initialization finishes.
// R4 - Software rechecks state 1 ms after F7 to F6 with INFO0 flag.
// R5 - TE goes F7 to F3 on INFO0, possibly via brief F6.
// R6 - NT sends INFO0/2/4 per state; activate or INFO1 leads to G2.
// R7 - NT deactivate enters G4 with 256-frame timer; expiry returns to G1.
// R8 - Software runs NT supervision timer and requests deactivation on expiry.
// R9 - NT G3 falls to G2 on INFO0 or lost framing; G4 INFO0 to G1.
// R10 - TE starts in F0, goes F2 on release, sends INFO1 in F4, INFO3 in F7.
// R11 - With sync, INFO2 enters F6 and INFO4 enters F7 from F2 to F8.
// R12 - TE lost sync in F6/F7 goes F8; INFO0 in F2/F6/F7/F8 goes F3.
// R13 - TE in F4 goes F5 on unclassified received signal.
// R14 - Software runs TE activation timer and forces F3 on expiry.
// R15 - Activate command in G2, G3, F6 or F7 leaves state unchanged.
// R16 - Software sets line clock delay before starting the machine.
// R17 - Every state change sets a read-clear summary flag; masked flag interrupts.
// R18 - Load bit overwrites state, state always readable, TE/NT selectable.
// R19 - Undefined transitions keep state; changes applied once per line frame.
`timescale 1ns/10ps

module lac_fsm
   import lac_pkg::*;
(
   input  wire logic                core_clk_in,
   input  wire logic                rst_in,
   input  wire logic                frame_tick_in,
   input  wire logic                te_nt_mode_select_in,
   input  wire logic                state_wr_in,
   input  wire logic                state_load_bit_in,
   input  wire logic [STNUM_W-1:0]  state_value_in,
   input  wire logic [1:0]          activation_command_in,
   input  wire logic                nt_pending_to_active_set_in,
   input  wire logic                nt_auto_activate_enable_in,
   input  wire logic [INFO_W-1:0]   rx_info_in,
   input  wire logic                rx_sync_in,
   input  wire logic                summary_rd_in,
   input  wire logic                state_change_mask_in,
   output logic [STNUM_W-1:0]       line_state_out,
   output logic [INFO_W-1:0]        tx_info_out,
   output logic                     info0_received_flag_out,
   output logic                     nt_pending_to_active_allow_out,
   output logic                     state_change_summary_out,
   output logic                     state_change_irq_out
);

   // -------------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------------
   function automatic lac_state_t num_to_state(input logic [STNUM_W-1:0] num);
      logic [STATE_W-1:0] oh;
      oh = '0;
      oh[num] = 1'b1;
      return lac_state_t'(oh);
   endfunction

   function automatic logic [STNUM_W-1:0] state_to_num(input lac_state_t st);
      logic [STNUM_W-1:0] num;
      num = '0;
      for (int i = 0; i < STATE_W; i++) begin
         if (st[i]) begin
            num = STNUM_W'(i);
         end
      end
      return num;
   endfunction

   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   lac_state_t            state;
   lac_state_t            next_state;
   logic                  held;
   logic                  next_held;
   logic [T2_CNT_W-1:0]   t2_cnt;
   logic [T2_CNT_W-1:0]   next_t2_cnt;
   logic                  allow;
   logic                  next_allow;
   logic                  pend_act;
   logic                  next_pend_act;
   logic                  pend_deact;
   logic                  next_pend_deact;
   logic                  info0_flag;
   logic                  next_info0_flag;
   logic [STNUM_W-1:0]    next_line_state;
   logic [INFO_W-1:0]     next_tx_info;
   logic                  summary;
   logic                  next_summary;
   logic                  next_irq;

   logic                  rx0;
   logic                  sig2;
   logic                  sig4;
   logic                  t2_done;
   logic                  nt_mode;
   logic [STNUM_W-1:0]    max_state;

   assign rx0       = (rx_info_in == INFO_0);
   assign sig2      = rx_sync_in && (rx_info_in == INFO_2);
   assign sig4      = rx_sync_in && (rx_info_in == INFO_4);
   assign t2_done   = (t2_cnt == T2_LAST);
   assign nt_mode   = (te_nt_mode_select_in == MODE_NT);
   assign max_state = nt_mode ? ST_MAX_NT : ST_MAX_TE;

   // -------------------------------------------------------------------------
   // Next-state logic
   // -------------------------------------------------------------------------
   always_comb begin
      next_state      = state;
      next_held       = held;
      next_t2_cnt     = t2_cnt;
      next_allow      = allow;
      next_pend_act   = pend_act;
      next_pend_deact = pend_deact;
      next_info0_flag = info0_flag;

      // R19 once per frame
      if (frame_tick_in && !held) begin
         next_pend_act   = 1'b0;
         next_pend_deact = 1'b0;
         next_info0_flag = rx0;
         if (nt_mode) begin
            unique case (state)
               // R6 release to G1
               LAC_S0: next_state = LAC_S1;
               // R6 G1 activation
               LAC_S1: begin
                  if (pend_act || rx_info_in == INFO_1) begin
                     next_state = LAC_S2;
                  end
               end
               LAC_S2: begin
                  if (pend_deact) begin
                     // R7 deactivate to G4
                     next_state = LAC_S4;
                  end else if (rx_sync_in && rx_info_in == INFO_3 &&
                               (allow || nt_auto_activate_enable_in)) begin
                     // R2 gated G2 to G3
                     next_state = LAC_S3;
                     next_allow = 1'b0;
                  end
               end
               LAC_S3: begin
                  if (pend_deact) begin
                     // R7 deactivate to G4
                     next_state = LAC_S4;
                  end else if (rx0 || !rx_sync_in) begin
                     // R9 fall back
                     next_state = LAC_S2;
                  end
               end
               LAC_S4: begin
                  if (pend_act) begin
                     // R6 G4 activation
                     next_state = LAC_S2;
                  end else if (t2_done || rx0) begin
                     // R7 timer expiry
                     // R9 INFO0 in G4
                     next_state = LAC_S1;
                  end
               end
               // R19 undefined keeps state
               default: next_state = state;
            endcase
         end else begin
            if (state == LAC_S0) begin
               // R10 release to F2
               next_state = LAC_S2;
            end else if (pend_deact) begin
               next_state = LAC_S3;
            end else if (rx0 && (state == LAC_S2 || state == LAC_S6 ||
                                 state == LAC_S7 || state == LAC_S8)) begin
               // R12 INFO0 to F3
               // R5 F7 to F3
               next_state = LAC_S3;
            end else if (sig2 && state != LAC_S1 && state != LAC_S6) begin
               // R11 INFO2 to F6
               next_state = LAC_S6;
            end else if (sig4 && state != LAC_S1 && state != LAC_S7) begin
               // R11 INFO4 to F7
               next_state = LAC_S7;
            end else if (!rx_sync_in && (state == LAC_S6 || state == LAC_S7)) begin
               // R12 lost sync to F8
               next_state = LAC_S8;
            end else if (state == LAC_S4 && rx_info_in == INFO_ANY) begin
               // R13 F4 to F5
               next_state = LAC_S5;
            end else if (state == LAC_S3 && pend_act) begin
               next_state = rx0 ? LAC_S4 : LAC_S5;
            end
         end
         // R7 deactivation timer
         if (next_state == LAC_S4 && state != LAC_S4) begin
            next_t2_cnt = T2_CNT_RESET;
         end else if (state == LAC_S4) begin
            next_t2_cnt = T2_CNT_W'(t2_cnt + 8'h01);
         end
      end

      // Register writes come last so a write beats the frame clear
      if (nt_pending_to_active_set_in && state_wr_in) begin
         next_allow = 1'b1;
      end
      if (state_wr_in) begin
         if (state_load_bit_in) begin
            // R18 direct overwrite
            if (state_value_in <= max_state) begin
               next_state = num_to_state(state_value_in);
            end
            next_held       = 1'b1;
            next_pend_act   = 1'b0;
            next_pend_deact = 1'b0;
         end else begin
            // R1 release on zero load bit
            next_held = 1'b0;
            // R15 activate while active keeps state
            if (activation_command_in == CMD_ACT) begin
               next_pend_act = 1'b1;
            end
            if (activation_command_in == CMD_DEACT) begin
               next_pend_deact = 1'b1;
            end
         end
      end

      next_line_state = state_to_num(next_state);
      // R1 held sends nothing
      // R6 NT line signal
      // R10 TE line signal
      next_tx_info = INFO_0;
      if (!next_held) begin
         if (nt_mode) begin
            if (next_state == LAC_S2) begin
               next_tx_info = INFO_2;
            end else if (next_state == LAC_S3) begin
               next_tx_info = INFO_4;
            end
         end else begin
            if (next_state == LAC_S4) begin
               next_tx_info = INFO_1;
            end else if (next_state == LAC_S7) begin
               next_tx_info = INFO_3;
            end
         end
      end

      // R17 change flag, set beats read clear
      next_summary = (summary && !summary_rd_in) || (next_state != state);
      next_irq     = next_summary && state_change_mask_in;
   end

   // -------------------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------------------
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         // R1 reset holds state 0
         state                          <= ST_RESET;
         held                           <= 1'b1;
         t2_cnt                         <= T2_CNT_RESET;
         allow                          <= 1'b0;
         pend_act                       <= 1'b0;
         pend_deact                     <= 1'b0;
         info0_flag                     <= 1'b0;
         summary                        <= 1'b0;
         line_state_out                 <= 4'h0;
         tx_info_out                    <= INFO_0;
         info0_received_flag_out        <= 1'b0;
         nt_pending_to_active_allow_out <= 1'b0;
         state_change_summary_out       <= 1'b0;
         state_change_irq_out           <= 1'b0;
      end else begin
         state                          <= next_state;
         held                           <= next_held;
         t2_cnt                         <= next_t2_cnt;
         allow                          <= next_allow;
         pend_act                       <= next_pend_act;
         pend_deact                     <= next_pend_deact;
         info0_flag                     <= next_info0_flag;
         summary                        <= next_summary;
         line_state_out                 <= next_line_state;
         tx_info_out                    <= next_tx_info;
         info0_received_flag_out        <= next_info0_flag;
         nt_pending_to_active_allow_out <= next_allow;
         state_change_summary_out       <= next_summary;
         state_change_irq_out           <= next_irq;
      end
   end

endmodule

// File: rtl/lac_pkg.sv
// Constants and types for the layer 1 activation machine of one line interface.
// Assumes all users import the whole package.
package lac_pkg;

   // -------------------------------------------------------------------------
   // State codes, one-hot; the index is the readable state number
   // -------------------------------------------------------------------------
   localparam int unsigned STATE_W   = 9;
   localparam int unsigned STNUM_W   = 4;
   localparam logic [3:0]  ST_MAX_TE = 4'h8;
   localparam logic [3:0]  ST_MAX_NT = 4'h4;

   typedef enum logic [STATE_W-1:0] {
      LAC_S0 = 9'h001,
      LAC_S1 = 9'h002,
      LAC_S2 = 9'h004,
      LAC_S3 = 9'h008,
      LAC_S4 = 9'h010,
      LAC_S5 = 9'h020,
      LAC_S6 = 9'h040,
      LAC_S7 = 9'h080,
      LAC_S8 = 9'h100
   } lac_state_t;

   localparam lac_state_t ST_RESET = LAC_S0;

   // -------------------------------------------------------------------------
   // Line signal codes, received and sent
   // -------------------------------------------------------------------------
   localparam int unsigned INFO_W   = 3;
   localparam logic [2:0]  INFO_0   = 3'h0;
   localparam logic [2:0]  INFO_1   = 3'h1;
   localparam logic [2:0]  INFO_2   = 3'h2;
   localparam logic [2:0]  INFO_3   = 3'h3;
   localparam logic [2:0]  INFO_4   = 3'h4;
   localparam logic [2:0]  INFO_ANY = 3'h5;

   // -------------------------------------------------------------------------
   // Activation command field
   // -------------------------------------------------------------------------
   localparam logic [1:0]  CMD_DEACT = 2'h2;
   localparam logic [1:0]  CMD_ACT   = 2'h3;

   // -------------------------------------------------------------------------
   // Mode select and timing
   // -------------------------------------------------------------------------
   localparam logic        MODE_TE       = 1'b0;
   localparam logic        MODE_NT       = 1'b1;
   localparam int unsigned FRAME_US      = 125;
   localparam int unsigned T2_FRAMES     = 256;
   localparam int unsigned T2_MS         = (T2_FRAMES * FRAME_US) / 1000;
   localparam int unsigned T2_CNT_W      = 8;
   localparam logic [7:0]  T2_LAST       = 8'(T2_FRAMES - 1);
   localparam logic [7:0]  T2_CNT_RESET  = 8'h00;

endpackage

// File: sim/lac_fsm_checker.sv
// Port assertions for the activation machine, bound to every instance.
// Assumes one-cycle write and frame pulses from the host side.
`timescale 1ns/10ps
module lac_fsm_checker
   import lac_pkg::*;
(
   input wire logic               core_clk_in,
   input wire logic               rst_in,
   input wire logic               frame_tick_in,
   input wire logic               te_nt_mode_select_in,
   input wire logic               state_wr_in,
   input wire logic               state_load_bit_in,
   input wire logic [STNUM_W-1:0] state_value_in,
   input wire logic [1:0]         activation_command_in,
   input wire logic               nt_pending_to_active_set_in,
   input wire logic               nt_auto_activate_enable_in,
   input wire logic [INFO_W-1:0]  rx_info_in,
   input wire logic               rx_sync_in,
   input wire logic               summary_rd_in,
   input wire logic               state_change_mask_in,
   input wire logic [STNUM_W-1:0] line_state_out,
   input wire logic [INFO_W-1:0]  tx_info_out,
   input wire logic               info0_received_flag_out,
   input wire logic               nt_pending_to_active_allow_out,
   input wire logic               state_change_summary_out,
   input wire logic               state_change_irq_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   wire logic nt = te_nt_mode_select_in == MODE_NT;
   sequence s_rd_quiet; summary_rd_in ##1 $stable(line_state_out); endsequence
   sequence s_g2_g3; nt && line_state_out == 4'h2 ##1 line_state_out == 4'h3; endsequence
   property p_idle; line_state_out == 4'h0 |-> tx_info_out == INFO_0; endproperty
   a_idle: assert property (p_idle) else $error("signal sent in state 0");
   property p_info2; tx_info_out == INFO_2 |-> nt && line_state_out == 4'h2; endproperty
   a_info2: assert property (p_info2) else $error("INFO2 outside G2");
   property p_info4; tx_info_out == INFO_4 |-> nt && line_state_out == 4'h3; endproperty
   a_info4: assert property (p_info4) else $error("INFO4 outside G3");
   property p_info3; tx_info_out == INFO_3 |-> !nt && line_state_out == 4'h7; endproperty
   a_info3: assert property (p_info3) else $error("INFO3 outside F7");
   // Moves only on a frame tick or a state write
   property p_cause;
      $changed(line_state_out) |-> $past(frame_tick_in) || $past(state_wr_in)
         || $past(state_wr_in, 2);
   endproperty
   a_cause: assert property (p_cause) else $error("state moved without cause");
   property p_set; $changed(line_state_out) |-> state_change_summary_out; endproperty
   a_set: assert property (p_set) else $error("change not flagged");
   property p_clr; s_rd_quiet |-> !state_change_summary_out; endproperty
   a_clr: assert property (p_clr) else $error("flag not cleared by read");
   property p_irq;
      state_change_irq_out == (state_change_summary_out && $past(state_change_mask_in));
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt not flag and mask");
   property p_allow;
      s_g2_g3 |-> $past(nt_pending_to_active_allow_out) || $past(nt_auto_activate_enable_in)
         || $past(state_wr_in) || $past(state_wr_in, 2);
   endproperty
   a_allow: assert property (p_allow) else $error("G3 entered without allow");
endmodule

bind lac_fsm lac_fsm_checker lac_fsm_checker_i (.*);

// File: sim/lac_fsm_tb.sv
// Self-checking bench: NT and TE flows, loads, T2 expiry, summary reads.
// Assumes the line partner model and the bound checker.
`timescale 1ns/10ps
module lac_fsm_tb
   import lac_pkg::*;
;
   logic               core_clk_in = 1'b0, rst_in = 1'b1, frame_tick_in = 1'b0;
   logic               te_nt_mode_select_in = MODE_NT, state_load_bit_in = 1'b1;
   logic               state_wr_in = 1'b0, rx_sync_in = 1'b1, ovr = 1'b0;
   logic               nt_pending_to_active_set_in = 1'b0, nt_auto_activate_enable_in = 1'b0;
   logic               summary_rd_in = 1'b0, state_change_mask_in = 1'b0;
   logic [STNUM_W-1:0] state_value_in = 4'h0, line_state_out, rnd;
   logic [1:0]         activation_command_in = 2'h0;
   logic [INFO_W-1:0]  rx_info_in, tx_info_out, ovr_info = INFO_0;
   logic               info0_received_flag_out, nt_pending_to_active_allow_out;
   logic               state_change_summary_out, state_change_irq_out;
   logic               held = 1'b1, exp_f0 = 1'b0, chk_now = 1'b0;
   logic [10:0]        got, exp_q[$];
   logic               exp_sum = 1'b0, exp_allow = 1'b0;
   logic [3:0]         last_s = 4'h0;
   int                 num_errors = 0, checked = 0, cycles = 0, seed;
   wire logic [10:0]   seen = {nt_pending_to_active_allow_out, state_change_summary_out,
                               state_change_irq_out, info0_received_flag_out, line_state_out,
                               tx_info_out};

   lac_fsm lac_fsm_i (.*);
   lac_line_partner lac_line_partner_i (.clk_in(core_clk_in), .as_te_in(te_nt_mode_select_in),
      .ovr_in(ovr), .ovr_info_in(ovr_info), .tx_info_in(tx_info_out), .rx_info_out(rx_info_in));

   always #2 core_clk_in = ~core_clk_in;

   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic wr(input logic l, input logic [3:0] v, input logic [1:0] c, input logic s);
      {state_load_bit_in, state_value_in, activation_command_in} <= {l, v, c};
      {nt_pending_to_active_set_in, state_wr_in} <= {s, 1'b1};
      @(posedge core_clk_in);
      {nt_pending_to_active_set_in, state_wr_in} <= 2'b00;
      held = l;
      exp_allow = exp_allow || s;
      @(posedge core_clk_in);
   endtask

   // Send n frame ticks with random read and mask, then note the expected outputs
   // A step moves the state on its first tick at most; the summary model relies on it
   task automatic step(input int n, input logic [3:0] s);
      logic [2:0] t;
      logic [1:0] r;
      repeat (n) begin
         @(posedge core_clk_in);
         r = 2'($urandom);
         {frame_tick_in, summary_rd_in, state_change_mask_in} <= {1'b1, r};
         @(posedge core_clk_in);
         {frame_tick_in, summary_rd_in} <= 2'b00;
         if (!held)
            exp_f0 = rx_info_in === INFO_0;
         if (te_nt_mode_select_in == MODE_NT && last_s == 4'h2 && s == 4'h3)
            exp_allow = 1'b0;
         exp_sum = (exp_sum && !r[1]) || (s != last_s);
         last_s = s;
      end
      exp_sum = exp_sum || (s != last_s);
      last_s = s;
      @(posedge core_clk_in);
      t = INFO_0;
      if (!held && te_nt_mode_select_in == MODE_NT)
         t = s == 4'h2 ? INFO_2 : s == 4'h3 ? INFO_4 : INFO_0;
      else if (!held)
         t = s == 4'h4 ? INFO_1 : s == 4'h7 ? INFO_3 : INFO_0;
      exp_q.push_back({exp_allow, exp_sum, exp_sum && state_change_mask_in, exp_f0, s, t});
      chk_now <= 1'b1;
      @(posedge core_clk_in);
      chk_now <= 1'b0;
      @(posedge core_clk_in);
   endtask

   always @(posedge core_clk_in) begin
      if (chk_now) begin
         got = exp_q.pop_front();
         checked++;
         if (seen !== got) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, got);
         end
      end
   end

   always @(posedge core_clk_in) begin
      cycles++;
      if (cycles == 6000) begin
         num_errors++;
         give_verdict();
      end
   end

   initial begin
      seed = $urandom(55102);
      repeat (6) @(posedge core_clk_in);
      rst_in <= 1'b0;
      @(posedge core_clk_in);
      step(1, 4'h0);
      // Release the machine: write with load bit zero and no command
      wr(1'b0, 4'h0, 2'h0, 1'b0);
      step(1, 4'h1);
      step(1, 4'h2);
      step(1, 4'h2);
      wr(1'b0, 4'h0, 2'h0, 1'b1);
      step(0, 4'h2);
      step(1, 4'h3);
      wr(1'b0, 4'h0, CMD_ACT, 1'b0);
      step(1, 4'h3);
      wr(1'b0, 4'h0, CMD_DEACT, 1'b0);
      step(1, 4'h4);
      step(T2_FRAMES - 1, 4'h4);
      step(1, 4'h1);
      step(1, 4'h2);
      nt_auto_activate_enable_in <= 1'b1;
      step(1, 4'h3);
      {ovr, ovr_info} <= {1'b1, INFO_0};
      step(1, 4'h2);
      ovr <= 1'b0;
      step(1, 4'h3);
      rx_sync_in <= 1'b0;
      step(1, 4'h2);
      {rx_sync_in, nt_auto_activate_enable_in} <= 2'b10;
      wr(1'b0, 4'h0, CMD_ACT, 1'b0);
      step(1, 4'h2);
      wr(1'b0, 4'h0, CMD_DEACT, 1'b0);
      step(1, 4'h4);
      {ovr, ovr_info} <= {1'b1, INFO_0};
      step(1, 4'h1);
      wr(1'b0, 4'h0, CMD_ACT, 1'b0);
      step(1, 4'h2);
      wr(1'b0, 4'h0, CMD_DEACT, 1'b0);
      step(1, 4'h4);
      wr(1'b0, 4'h0, CMD_ACT, 1'b0);
      step(1, 4'h2);
      $display("NT flow finished");
      {rst_in, te_nt_mode_select_in} <= {1'b1, MODE_TE};
      {held, exp_f0} = 2'b10;
      {exp_sum, exp_allow, last_s} = 6'h00;
      repeat (6) @(posedge core_clk_in);
      rst_in <= 1'b0;
      @(posedge core_clk_in);
      step(1, 4'h0);
      wr(1'b0, 4'h0, 2'h0, 1'b0);
      step(1, 4'h2);
      step(1, 4'h3);
      wr(1'b0, 4'h0, CMD_ACT, 1'b0);
      step(1, 4'h4);
      ovr_info <= INFO_ANY;
      step(1, 4'h5);
      ovr_info <= INFO_2;
      step(1, 4'h6);
      wr(1'b0, 4'h0, CMD_ACT, 1'b0);
      step(1, 4'h6);
      ovr_info <= INFO_4;
      step(2, 4'h7);
      ovr_info <= INFO_0;
      step(1, 4'h3);
      ovr_info <= INFO_2;
      step(1, 4'h6);
      {rx_sync_in, ovr_info} <= {1'b0, INFO_ANY};
      step(1, 4'h8);
      {rx_sync_in, ovr_info} <= {1'b1, INFO_4};
      step(1, 4'h7);
      repeat (3) begin
         rnd = 4'(1 + $urandom % 8);
         wr(1'b1, rnd, 2'h0, 1'b0);
         step(0, rnd);
      end
      // Load above the mode's last state is refused but still holds
      wr(1'b1, 4'hf, 2'h0, 1'b0);
      step(0, rnd);
      wr(1'b0, 4'h0, CMD_DEACT, 1'b0);
      step(1, 4'h3);
      ovr_info <= INFO_ANY;
      wr(1'b0, 4'h0, CMD_ACT, 1'b0);
      step(1, 4'h5);
      // Far NT model answers the silent line with INFO2
      ovr <= 1'b0;
      step(1, 4'h6);
      $display("TE flow finished");
      give_verdict();
   end
endmodule

// File: sim/lac_line_partner.sv
// Far line end: answers the device's INFO signal as a remote TE or NT.
// Assumes the bench picks the role and may force the reply.
`timescale 1ns/10ps
module lac_line_partner
   import lac_pkg::*;
(
   input  wire logic              clk_in,
   input  wire logic              as_te_in,
   input  wire logic              ovr_in,
   input  wire logic [INFO_W-1:0] ovr_info_in,
   input  wire logic [INFO_W-1:0] tx_info_in,
   output logic      [INFO_W-1:0] rx_info_out
);
   initial rx_info_out = INFO_0;
   // A far TE sends INFO1 while it hears INFO0 and INFO3 otherwise; a far NT answers INFO3 with INFO4
   always @(posedge clk_in) begin
      if (ovr_in)
         rx_info_out <= ovr_info_in;
      else if (as_te_in)
         rx_info_out <= (tx_info_in == INFO_0) ? INFO_1 : INFO_3;
      else
         rx_info_out <= (tx_info_in == INFO_3) ? INFO_4 : INFO_2;
   end
endmodule
